// ### rtl/serial_port_pkg.sv
package serial_port_pkg;

    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int BCNT_W = 4;
    localparam int FOSC_DIV = 4;
    localparam int DIV_CNT_W = 12;

    localparam logic [BCNT_W-1:0] LAST_BIT_16 = 4'hf;
    localparam logic [BCNT_W-1:0] LAST_BIT_8 = 4'h7;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [BCNT_W-1:0] BCNT_RESET = 4'h0;
    localparam logic [DIV_CNT_W-1:0] DIV_RESET = 12'h000;

    // frame_sync_direction encoding
    localparam logic FRAME_SYNC_PULSE_GENERATE = 1'b0;
    localparam logic FRAME_SYNC_PULSE_RECEIVE = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FRAME = 3'b010,
        ST_SHIFT = 3'b100
    } xfer_state_e;

    typedef struct packed {
        logic enable;
        logic master_mode;
        logic word_width_select;
        logic clock_idle_polarity;
        logic clock_edge_select;
        logic serial_out_disable;
        logic framed_mode_enable;
        logic frame_sync_direction;
        logic slave_select_enable;
        logic stop_in_idle;
        logic [1:0] primary_prescale;
        logic [2:0] secondary_prescale;
    } serial_cfg_s;

    typedef struct packed {
        logic transfer_done_flag;
        logic receive_overflow_flag;
        logic rx_full;
        logic tx_full;
    } serial_status_s;

    // outgoing bit of a word: bit 7 for bytes, bit 15 for words
    function automatic logic msb_bit(input logic [WORD_W-1:0] word, input logic wide);
        msb_bit = wide ? word[WORD_W-1] : word[BYTE_W-1];
    endfunction

    // sys clocks per serial half period, minus one
    function automatic logic [DIV_CNT_W-1:0] half_limit(input logic [1:0] pp,
                                                        input logic [2:0] sp);
        logic [DIV_CNT_W-1:0] p;
        logic [DIV_CNT_W-1:0] s;
        p = DIV_CNT_W'(1) << (2 * pp);
        s = DIV_CNT_W'(sp) + DIV_CNT_W'(1);
        half_limit = DIV_CNT_W'((FOSC_DIV / 2) * p * s - 1);
    endfunction

endpackage

// ### rtl/serial_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

module serial_clock_divider
    import serial_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] primary_prescale,
    input wire logic [2:0] secondary_prescale,
    output logic half_tick
);

    logic [DIV_CNT_W-1:0] cnt_q;
    logic at_limit;

    assign at_limit = (cnt_q >= half_limit(primary_prescale, secondary_prescale));
    assign half_tick = run & at_limit;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !run || at_limit) begin
            cnt_q <= DIV_RESET;
        end else begin
            cnt_q <= cnt_q + DIV_CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// ### rtl/framed_spi_port.sv
// Function
// - each transfer is 8 or 16 clock pulses, plus the frame pulse clock in framed mode; one bit out and one in per data pulse
// - completion sets the done flag; interrupt only when its enable is set
// - a completed received word is copied into the receive buffer
// - unread buffer at completion sets overflow, drops new word, keeps buffer
// - while overflow is set serial clocks are ignored until buffer read
// - transfer end moves shift register to rx and loads pending tx word
// - one data address: writes fill tx buffer, reads return rx buffer
// - master drives the serial clock pin; slave takes it as input
// - master starts as soon as a word is written, clock from prescaler
// - master flags completion at middle of the last bit
// - slave shifts on external clocks, flags when last bit latched
// - master clock is fosc/4 through primary then secondary prescale
// - edge select picks which clock transition changes output data
// - polarity bit sets the idle level of the serial clock
// - width bit selects 16 or 8 bit transfers, otherwise identical
// - width changes only while disabled; change resets transfer logic
// - output from bit 7 or bit 15, input enters at bit 0
// - output disable releases data out pin for receive-only use
// - framed mode turns slave select into frame sync pin, both roles
// - direction bit chooses generate or receive one-clock high frame pulse
// - framed data starts on transmit edge following the frame pulse
// - slave select high releases output and resets bit counters
// - sleep aborts transfer, stops port, keeps register contents
// - stop-in-idle bit halts port in idle when set
`timescale 1ns/1ps
`default_nettype none

module framed_spi_port
    import serial_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire serial_cfg_s cfg,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic transfer_done_irq_enable,
    input wire logic transfer_done_clear,
    input wire logic buf_wr,
    input wire logic [WORD_W-1:0] buf_wdata,
    input wire logic buf_rd,
    output logic [WORD_W-1:0] buf_rdata,
    output serial_status_s status,
    output logic irq,
    input wire logic serial_in_pin,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic slave_select_pin_i,
    output logic slave_select_pin_o,
    output logic slave_select_pin_oe,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe
);

    xfer_state_e state_q, state_d;
    logic [WORD_W-1:0] sr_q, tx_q, rx_q;
    logic [WORD_W-1:0] new_word;
    logic [BCNT_W-1:0] bcnt_q, last_bit;
    logic tx_full_q, rx_full_q, ovf_q, done_flag_q;
    logic out_q, sck_q, frame_sync_pulse_q, arm_q, begun_q, width_q;
    logic sdi_s1, sdi_s2, sck_s1, sck_s2, sck_s3, ss_s1, ss_s2;
    logic run, width_chg, ss_block, xfer_rst;
    logic half_tick, div_run, edge_any, lead, sample_e, change_e;
    logic start_m, load, done, rx_free, frame_sync_pulse_lvl, gen_frame_sync_pulse;

    // two-stage pin synchronisers; sck has a third stage for edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
        end else begin
            sdi_s1 <= serial_in_pin;
            sdi_s2 <= sdi_s1;
            sck_s1 <= serial_clock_pin_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            ss_s1 <= slave_select_pin_i;
            ss_s2 <= ss_s1;
        end
    end

    assign run = cfg.enable & ~cpu_sleep & ~(cpu_idle & cfg.stop_in_idle);
    assign width_chg = (width_q != cfg.word_width_select);
    assign ss_block = ~cfg.master_mode & cfg.slave_select_enable
                    & ~cfg.framed_mode_enable & ss_s2;
    assign xfer_rst = ~run | width_chg | ss_block;
    assign last_bit = cfg.word_width_select ? LAST_BIT_16 : LAST_BIT_8;
    assign gen_frame_sync_pulse = (cfg.frame_sync_direction == FRAME_SYNC_PULSE_GENERATE);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            width_q <= 1'b0;
        end else begin
            width_q <= cfg.word_width_select;
        end
    end

    // master clock generation
    assign div_run = cfg.master_mode & ~xfer_rst
                   & ((state_q != ST_IDLE) | (sck_q != cfg.clock_idle_polarity));

    serial_clock_divider u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(div_run),
        .primary_prescale(cfg.primary_prescale),
        .secondary_prescale(cfg.secondary_prescale),
        .half_tick(half_tick)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else if (xfer_rst || !cfg.master_mode) begin
            sck_q <= cfg.clock_idle_polarity;
        end else if (half_tick) begin
            sck_q <= ~sck_q;
        end
    end

    // edge classification, common to both roles
    always_comb begin
        if (cfg.master_mode) begin
            edge_any = half_tick;
            lead = (sck_q == cfg.clock_idle_polarity);
        end else begin
            edge_any = sck_s2 ^ sck_s3;
            lead = (sck_s3 == cfg.clock_idle_polarity);
        end
        edge_any = edge_any & ~ovf_q & ~xfer_rst;
        sample_e = edge_any & (lead == cfg.clock_edge_select);
        change_e = edge_any & (lead != cfg.clock_edge_select);
    end

    assign start_m = tx_full_q & ~ovf_q & (sck_q == cfg.clock_idle_polarity);
    assign done = (state_q == ST_SHIFT) & sample_e & (bcnt_q == last_bit);
    assign frame_sync_pulse_lvl = gen_frame_sync_pulse ? frame_sync_pulse_q : ss_s2;

    always_comb begin
        if (cfg.master_mode) begin
            load = tx_full_q & (state_q == ST_IDLE) & start_m & ~xfer_rst;
        end else begin
            load = tx_full_q & ~begun_q & ~edge_any & ~xfer_rst & ~ovf_q;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cfg.master_mode ? start_m : ~ovf_q) begin
                    state_d = cfg.framed_mode_enable ? ST_FRAME : ST_SHIFT;
                end
            end
            ST_FRAME: begin
                if (change_e && arm_q) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (done) begin
                    if (cfg.master_mode) begin
                        state_d = ST_IDLE;
                    end else if (cfg.framed_mode_enable) begin
                        state_d = ST_FRAME;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (xfer_rst) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // frame sync generation and arming
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_sync_pulse_q <= 1'b0;
        end else if (xfer_rst || !cfg.framed_mode_enable || !gen_frame_sync_pulse) begin
            frame_sync_pulse_q <= 1'b0;
        end else if (state_d == ST_FRAME && state_q != ST_FRAME) begin
            frame_sync_pulse_q <= 1'b1;
        end else if (edge_any && !lead) begin
            frame_sync_pulse_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            arm_q <= 1'b0;
        end else if (state_q != ST_FRAME) begin
            arm_q <= 1'b0;
        end else if (sample_e && frame_sync_pulse_lvl) begin
            arm_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            begun_q <= 1'b0;
        end else if (xfer_rst || done) begin
            begun_q <= 1'b0;
        end else if ((state_q == ST_SHIFT && sample_e)
                     || (state_q == ST_FRAME && change_e && arm_q)) begin
            begun_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bcnt_q <= BCNT_RESET;
        end else if (xfer_rst || state_q != ST_SHIFT || done) begin
            bcnt_q <= BCNT_RESET;
        end else if (sample_e) begin
            bcnt_q <= bcnt_q + BCNT_W'(1);
        end
    end

    // shift register and output bit
    assign new_word = {sr_q[WORD_W-2:0], sdi_s2};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sr_q <= WORD_RESET;
        end else if (load) begin
            sr_q <= tx_q;
        end else if (sample_e && state_q == ST_SHIFT) begin
            sr_q <= new_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_q <= 1'b0;
        end else if (load) begin
            out_q <= msb_bit(tx_q, cfg.word_width_select);
        end else if (change_e && state_q != ST_IDLE) begin
            out_q <= msb_bit(sr_q, cfg.word_width_select);
        end
    end

    // transmit holding buffer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_q <= WORD_RESET;
        end else if (buf_wr) begin
            tx_q <= buf_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_full_q <= 1'b0;
        end else if (buf_wr) begin
            tx_full_q <= 1'b1;
        end else if (load) begin
            tx_full_q <= 1'b0;
        end
    end

    // receive holding buffer and overflow
    assign rx_free = ~rx_full_q | buf_rd;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_q <= WORD_RESET;
        end else if (done && rx_free) begin
            rx_q <= cfg.word_width_select ? new_word
                  : {{(WORD_W-BYTE_W){1'b0}}, new_word[BYTE_W-1:0]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_full_q <= 1'b0;
        end else if (done && rx_free) begin
            rx_full_q <= 1'b1;
        end else if (buf_rd) begin
            rx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else if (done && !rx_free) begin
            ovf_q <= 1'b1;
        end else if (buf_rd) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_flag_q <= 1'b0;
        end else if (done) begin
            done_flag_q <= 1'b1;
        end else if (transfer_done_clear) begin
            done_flag_q <= 1'b0;
        end
    end

    assign irq = done_flag_q & transfer_done_irq_enable;
    assign buf_rdata = rx_q;
    assign status = '{transfer_done_flag: done_flag_q, receive_overflow_flag: ovf_q,
                      rx_full: rx_full_q, tx_full: tx_full_q};

    // pins
    assign serial_clock_pin_o = sck_q;
    assign serial_clock_pin_oe = cfg.master_mode;
    assign serial_out_pin_o = out_q;
    assign serial_out_pin_oe = run & ~cfg.serial_out_disable
                             & (cfg.master_mode | ~cfg.slave_select_enable
                                | cfg.framed_mode_enable | ~ss_s2);
    assign slave_select_pin_o = frame_sync_pulse_q;
    assign slave_select_pin_oe = cfg.enable & cfg.framed_mode_enable & gen_frame_sync_pulse;

endmodule

`default_nettype wire

// ### test/framed_spi_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

module framed_spi_port_sva
    import serial_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire serial_cfg_s cfg,
    input wire logic transfer_done_irq_enable,
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic [WORD_W-1:0] buf_rdata,
    input wire serial_status_s status,
    input wire logic irq,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic slave_select_pin_i,
    input wire logic serial_out_pin_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_irq_gated: assert property (irq == (status.transfer_done_flag && transfer_done_irq_enable))
        else $error("irq does not follow flag and enable");
    a_sck_direction: assert property (serial_clock_pin_oe == cfg.master_mode)
        else $error("clock pin direction wrong");
    a_sdo_off_disable: assert property (cfg.serial_out_disable [*2] |-> !serial_out_pin_oe)
        else $error("data out driven while disabled");
    a_sdo_off_deselect: assert property ((!cfg.master_mode && cfg.slave_select_enable
        && !cfg.framed_mode_enable && slave_select_pin_i) [*4] |-> !serial_out_pin_oe)
        else $error("data out driven while deselected");
    a_idle_clock_level: assert property ((cfg.master_mode && !cfg.enable
        && $stable(cfg.clock_idle_polarity)) [*2] |-> serial_clock_pin_o == cfg.clock_idle_polarity)
        else $error("clock not at idle level");
    a_wr_fills_tx: assert property (buf_wr |=> status.tx_full)
        else $error("write not taken into transmit buffer");
    a_rx_with_flag: assert property ($rose(status.rx_full) |-> status.transfer_done_flag)
        else $error("word received without done flag");
    a_ovf_keeps_buf: assert property (status.receive_overflow_flag && !buf_rd |=> $stable(buf_rdata))
        else $error("buffer changed during overflow");
    a_ovf_holds_tx: assert property (status.receive_overflow_flag && status.tx_full && !buf_rd
        |=> status.tx_full)
        else $error("pending word started during overflow");
    a_read_clears_ovf: assert property (buf_rd |=> !status.receive_overflow_flag)
        else $error("overflow not cleared by read");
endmodule

bind framed_spi_port framed_spi_port_sva chk_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg(cfg),
    .transfer_done_irq_enable(transfer_done_irq_enable),
    .buf_wr(buf_wr),
    .buf_rd(buf_rd),
    .buf_rdata(buf_rdata),
    .status(status),
    .irq(irq),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe(serial_clock_pin_oe),
    .slave_select_pin_i(slave_select_pin_i),
    .serial_out_pin_oe(serial_out_pin_oe)
);

`default_nettype wire

// ### test/spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_peer_model (
    input wire logic clk_sys,
    input wire logic sck_w,
    input wire logic mosi,
    input wire logic wide,
    input wire logic cpol,
    input wire logic cke,
    output logic miso,
    output logic sck_gen,
    output logic ss_n
);
    logic [15:0] tx_q = 16'h0000;
    logic [15:0] rx_q = 16'h0000;
    logic busy = 1'b0;
    logic last = 1'b0;
    int edges = 0;

    // released line shows the inverse of its last bit
    assign miso = busy ? (wide ? tx_q[15] : tx_q[7]) : ~last;
    initial begin
        sck_gen = 1'b0;
        ss_n = 1'b1;
    end

    task automatic prime(input logic [15:0] w);
        tx_q = w;
        edges = 0;
        busy = 1'b1;
    endtask

    always @(sck_w) begin
        if (busy) begin
            if ((sck_w != cpol) == cke) begin
                rx_q = {rx_q[14:0], mosi};
            end else if (edges != 0) begin
                last = miso;
                tx_q = tx_q << 1;
            end
            edges++;
            if (edges == (wide ? 32 : 16)) begin
                busy = 1'b0;
            end
        end
    end

    // master role: select low for the whole word
    task automatic drive(input int bits, input int half);
        #1 ss_n = 1'b0;
        repeat (half) @(posedge clk_sys);
        repeat (2 * bits) begin
            repeat (half) @(posedge clk_sys);
            #1 sck_gen = ~sck_gen;
        end
        repeat (half) @(posedge clk_sys);
        #1 ss_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// ### test/framed_spi_port_test.sv
`timescale 1ns/1ps
`default_nettype none

module framed_spi_port_test;
    import serial_port_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    serial_cfg_s cfg = '0;
    logic cpu_sleep = 1'b0;
    logic cpu_idle = 1'b0;
    int n_fs = 0;
    logic irq_en = 1'b0;
    logic done_clr = 1'b0;
    logic buf_wr = 1'b0;
    logic buf_rd = 1'b0;
    logic [15:0] buf_wdata = 16'h0000;
    logic [15:0] buf_rdata;
    serial_status_s status;
    logic irq, sck_o, sck_oe, ss_o, ss_oe, sdo_o, sdo_oe, miso, sck_gen, ss_n;
    wire logic sck_w = sck_oe ? sck_o : sck_gen;
    wire logic ss_w = ss_oe ? ss_o : ss_n;
    int n_errors = 0;
    int n_tests = 0;
    int n_edges = 0;
    int cycles = 0;

    framed_spi_port dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .transfer_done_irq_enable(irq_en), .transfer_done_clear(done_clr),
        .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd), .buf_rdata(buf_rdata),
        .status(status), .irq(irq), .serial_in_pin(miso), .serial_clock_pin_i(sck_w),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
        .slave_select_pin_i(ss_w), .slave_select_pin_o(ss_o), .slave_select_pin_oe(ss_oe),
        .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe)
    );
    spi_peer_model peer_u (
        .clk_sys(clk_sys), .sck_w(sck_w), .mosi(sdo_oe ? sdo_o : ~sdo_o),
        .wide(cfg.word_width_select), .cpol(cfg.clock_idle_polarity),
        .cke(cfg.clock_edge_select), .miso(miso), .sck_gen(sck_gen), .ss_n(ss_n)
    );

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(sck_w) n_edges++;
    // clock cycles with the frame pulse driven high
    always @(negedge clk_sys) begin
        if (ss_oe && ss_o) begin
            n_fs++;
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic put(input logic [15:0] w);
        @(posedge clk_sys);
        #1 buf_wr = 1'b1;
        buf_wdata = w;
        @(posedge clk_sys);
        #1 buf_wr = 1'b0;
    endtask
    task automatic take(input logic [15:0] exp);
        check(buf_rdata, exp);
        @(posedge clk_sys);
        #1 buf_rd = 1'b1;
        @(posedge clk_sys);
        #1 buf_rd = 1'b0;
    endtask
    task automatic wait_done(input logic exp_irq);
        int i;
        i = 0;
        @(posedge clk_sys);
        #1;
        while (status.transfer_done_flag !== 1'b1 && i < 2000) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        check(16'(status.transfer_done_flag), 16'h0001);
        check(16'(irq), 16'(exp_irq));
        done_clr = 1'b1;
        @(posedge clk_sys);
        #1 done_clr = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
    endtask
    // port held off while width or polarity change
    task automatic setup(input serial_cfg_s c);
        serial_cfg_s d;
        d = c;
        d.enable = 1'b0;
        @(posedge clk_sys);
        #1 cfg = d;
        repeat (3) @(posedge clk_sys);
        #1 cfg = c;
        repeat (4) @(posedge clk_sys);
        n_edges = 0;
    endtask
    function automatic serial_cfg_s mk(input logic m, input logic w, input logic p,
                                       input logic [1:0] pp, input logic [2:0] sp);
        mk = '0;
        mk.enable = 1'b1;
        mk.master_mode = m;
        mk.word_width_select = w;
        mk.clock_idle_polarity = p;
        mk.clock_edge_select = 1'b1;
        mk.slave_select_enable = !m;
        mk.primary_prescale = pp;
        mk.secondary_prescale = sp;
    endfunction

    initial begin
        serial_cfg_s c;
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        irq_en = 1'b1;
        setup(mk(1'b1, 1'b0, 1'b0, 2'h0, 3'h1));
        check(16'(sck_o), 16'h0000);
        peer_u.prime(16'h00c3);
        put(16'h5aa5);
        wait_done(1'b1);
        check(16'(n_edges), 16'h0010);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h00a5);
        take(16'h00c3);
        irq_en = 1'b0;
        setup(mk(1'b1, 1'b1, 1'b1, 2'h1, 3'h0));
        check(16'(sck_o), 16'h0001);
        peer_u.prime(16'h1234);
        put(16'hbeef);
        wait_done(1'b0);
        check(16'(n_edges), 16'h0020);
        check(peer_u.rx_q, 16'hbeef);
        peer_u.prime(16'h0f0f);
        put(16'h3333);
        wait_done(1'b0);
        check(16'(status.receive_overflow_flag), 16'h0001);
        check(buf_rdata, 16'h1234);
        n_edges = 0;
        put(16'h4444);
        repeat (100) @(posedge clk_sys);
        check(16'(n_edges), 16'h0000);
        peer_u.prime(16'h5555);
        take(16'h1234);
        wait_done(1'b0);
        check(16'(status.receive_overflow_flag), 16'h0000);
        check(peer_u.rx_q, 16'h4444);
        take(16'h5555);
        setup(mk(1'b0, 1'b0, 1'b0, 2'h0, 3'h0));
        check(16'(sdo_oe), 16'h0000);
        check(16'(sck_oe), 16'h0000);
        put(16'h003c);
        peer_u.prime(16'h0096);
        peer_u.drive(8, 8);
        wait_done(1'b0);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h003c);
        take(16'h0096);
        c = mk(1'b1, 1'b0, 1'b0, 2'h0, 3'h1);
        c.serial_out_disable = 1'b1;
        setup(c);
        peer_u.prime(16'h0081);
        put(16'h00ff);
        repeat (10) @(posedge clk_sys);
        check(16'(sdo_oe), 16'h0000);
        wait_done(1'b0);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h0000);
        take(16'h0081);
        c = mk(1'b1, 1'b0, 1'b1, 2'h0, 3'h1);
        c.clock_edge_select = 1'b0;
        c.stop_in_idle = 1'b1;
        setup(c);
        check(16'(sck_o), 16'h0001);
        peer_u.prime(16'h00b4);
        put(16'h002d);
        wait_done(1'b0);
        check(16'(n_edges), 16'h0010);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h002d);
        take(16'h00b4);
        cpu_idle = 1'b1;
        n_edges = 0;
        put(16'h0011);
        repeat (100) @(posedge clk_sys);
        check(16'(n_edges), 16'h0000);
        peer_u.prime(16'h0042);
        cpu_idle = 1'b0;
        wait_done(1'b0);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h0011);
        take(16'h0042);
        c = mk(1'b1, 1'b0, 1'b0, 2'h0, 3'h1);
        c.framed_mode_enable = 1'b1;
        setup(c);
        put(16'h00a6);
        @(negedge ss_w);
        #1 peer_u.prime(16'h0059);
        wait_done(1'b0);
        check(16'(n_edges), 16'h0012);
        check(16'(n_fs), 16'h0008);
        check({8'h00, peer_u.rx_q[7:0]}, 16'h00a6);
        take(16'h0059);
        cpu_sleep = 1'b1;
        n_edges = 0;
        put(16'h0011);
        repeat (100) @(posedge clk_sys);
        check(16'(n_edges), 16'h0000);
        complete_run();
    end
endmodule

`default_nettype wire
